/* logic/tmr_map.svh */
// Purpose: Register addresses, field positions, reset values and timing counts.
// Assumes: Included by its bare name from the design modules.
// Notes: Definitions only.
`ifndef TMR_MAP_SVH
`define TMR_MAP_SVH

`define TMR_RD_STATUS      8'h02
`define TMR_RD_CONFIG      8'h03
`define TMR_RD_RATE        8'h04
`define TMR_WR_CONFIG      8'h09
`define TMR_WR_RATE        8'h0a
`define TMR_WR_ONESHOT     8'h0f
`define TMR_RW_FAULTQ      8'h22
`define TMR_RD_PARTID      8'h3d
`define TMR_RD_MAKER       8'hfe
`define TMR_RD_REV         8'hff

`define TMR_CFG_MASK_BIT     7
`define TMR_CFG_STANDBY_BIT  6
`define TMR_CFG_ROLE_BIT     5
`define TMR_CFG_BETA_OFF_BIT 4
`define TMR_CFG_RANGE_BIT    2
`define TMR_CFG_RESET        8'h08
`define TMR_CFG_WR_MASK      8'hf4

`define TMR_RATE_RESET     4'h6
`define TMR_RATE_MAX       4'ha

`define TMR_FAULTQ_RESET   8'h01
`define TMR_FAULTQ_WR_MASK 8'hcf

`define TMR_ST_BUSY_BIT    7
`define TMR_ST_LHI_BIT     6
`define TMR_ST_LLO_BIT     5
`define TMR_ST_RHI_BIT     4
`define TMR_ST_RLO_BIT     3
`define TMR_ST_OPEN_BIT    2
`define TMR_ST_ROT_BIT     1
`define TMR_ST_LOT_BIT     0

`define TMR_CLK_PERIOD_NS  10
`define TMR_MS_NS          1000000
`define TMR_MS_CYCLES      (`TMR_MS_NS / `TMR_CLK_PERIOD_NS)

`define TMR_PERIOD_MS_0    16'd16000
`define TMR_PERIOD_MS_1    16'd8000
`define TMR_PERIOD_MS_2    16'd4000
`define TMR_PERIOD_MS_3    16'd2000
`define TMR_PERIOD_MS_4    16'd1000
`define TMR_PERIOD_MS_5    16'd500
`define TMR_PERIOD_MS_6    16'd250
`define TMR_PERIOD_MS_7    16'd200
`define TMR_PERIOD_MS_8    16'd100
`define TMR_PERIOD_MS_9    16'd50
`define TMR_PERIOD_MS_10   16'd27

`endif

/* logic/tmr_pkg.sv */
// Purpose: Types shared by the monitor register bank.
// Assumes: Constants live in tmr_map.svh.
// Notes: Types only.
`default_nettype none
package tmr_pkg;

  typedef struct packed {
    logic busy;
    logic local_upper_trip_flag;
    logic local_lower_trip_flag;
    logic remote_upper_trip_flag;
    logic remote_lower_trip_flag;
    logic diode_open;
    logic remote_overtemp_flag;
    logic local_overtemp_flag;
    logic remote_second_over;
    logic local_second_over;
  } tmr_meas_type;

  typedef struct packed {
    logic standby;
    logic beta_cancel_off;
    logic ext_range;
  } tmr_cfg_type;

endpackage

`default_nettype wire

/* logic/tmr_rate_timer.sv */
// Purpose: Paces conversion starts from the measurement rate code.
// Assumes: One clock, one millisecond prescaler.
// Notes: Codes above the table repeat the fastest rate.
`timescale 1ns/1ps
`default_nettype none
`include "tmr_map.svh"

module tmr_rate_timer #(
  parameter int unsigned MS_CYCLES = `TMR_MS_CYCLES
) (
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic [3:0] rate_code,
  input  wire logic       standby,
  input  wire logic       one_shot,
  output var  logic       conv_start_ff
);
  logic [31:0] pre_ff;
  logic [15:0] ms_ff;
  logic [15:0] period_ms;
  logic        ms_tick;
  logic        period_done;
  logic        nxt_start;

  always_comb begin
    case (rate_code)
      4'h0:    period_ms = `TMR_PERIOD_MS_0;
      4'h1:    period_ms = `TMR_PERIOD_MS_1;
      4'h2:    period_ms = `TMR_PERIOD_MS_2;
      4'h3:    period_ms = `TMR_PERIOD_MS_3;
      4'h4:    period_ms = `TMR_PERIOD_MS_4;
      4'h5:    period_ms = `TMR_PERIOD_MS_5;
      4'h6:    period_ms = `TMR_PERIOD_MS_6;
      4'h7:    period_ms = `TMR_PERIOD_MS_7;
      4'h8:    period_ms = `TMR_PERIOD_MS_8;
      4'h9:    period_ms = `TMR_PERIOD_MS_9;
      default: period_ms = `TMR_PERIOD_MS_10;
    endcase
  end

  assign ms_tick     = (pre_ff == MS_CYCLES - 1);
  // A shortened period after a rate change ends on the next tick, never runs long.
  assign period_done = ms_tick && (ms_ff >= period_ms - 16'h0001);
  // Standby stops periodic starts; a single trigger still runs one conversion.
  assign nxt_start   = one_shot || (!standby && period_done);

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pre_ff        <= 32'h0;
      ms_ff         <= 16'h0;
      conv_start_ff <= 1'b0;
    end else begin
      pre_ff        <= (standby || ms_tick) ? 32'h0 : pre_ff + 32'h1;
      ms_ff         <= (standby || period_done) ? 16'h0 : (ms_tick ? ms_ff + 16'h1 : ms_ff);
      conv_start_ff <= nxt_start;
    end
  end
endmodule // tmr_rate_timer

`default_nettype wire

/* logic/tmr_regs.sv */
// Purpose: Status and configuration registers of a remote plus local temperature monitor.
// Assumes: The serial protocol engine and the comparators run on sys_clk.
// Notes: Registers are reached through the internal pointer with read and write addresses.
`timescale 1ns/1ps
`default_nettype none
`include "tmr_map.svh"

module tmr_regs #(
  parameter int unsigned MS_CYCLES  = `TMR_MS_CYCLES,
  parameter logic [7:0]  PART_CODE  = 8'h5a, // Arbitrary value.
  parameter logic [7:0]  MAKER_CODE = 8'h3c, // Arbitrary value.
  parameter logic [7:0]  REV_CODE   = 8'h01  // Arbitrary value.
) (
  input  wire logic                  sys_clk,
  input  wire logic                  rst,
  input  wire logic                  ptr_load,
  input  wire logic                  wr_req,
  input  wire logic                  rd_req,
  input  wire logic [7:0]            wr_data,
  input  wire tmr_pkg::tmr_meas_type meas,
  output var  logic [7:0]            rd_data_ff,
  output var  logic                  rd_valid_ff,
  output var  tmr_pkg::tmr_cfg_type  cfg_ff,
  output var  logic [3:0]            rate_code_ff,
  output var  logic [7:0]            fault_queue_ff,
  output var  logic                  conv_start_ff,
  output var  logic                  shared_pin_out_ff,
  output var  logic                  shared_pin_oe_n_ff,
  output var  logic                  overtemp_out_n_ff,
  output var  logic                  overtemp_out_n_oe_n_ff
);
  import tmr_pkg::*;

  logic [7:0] ptr_ff;
  logic [7:0] config_ff;
  logic [4:0] sticky_ff;
  logic [7:0] nxt_config;
  logic [3:0] nxt_rate;
  logic [7:0] nxt_fault_queue;
  logic [4:0] nxt_sticky;
  logic [4:0] trip_events;
  logic [7:0] status_word;
  logic [7:0] nxt_rd_data;
  logic       wr_config;
  logic       wr_rate;
  logic       wr_oneshot;
  logic       wr_fault_queue;
  logic       status_read;
  logic       mask_on;
  logic       role_second;
  logic       limit_pending;
  logic       nxt_shared_active;
  logic       nxt_overtemp_active;

  // Write decode against the pointer; the register set behaves the same in standby.
  assign wr_config      = wr_req && (ptr_ff == `TMR_WR_CONFIG);
  assign wr_rate        = wr_req && (ptr_ff == `TMR_WR_RATE);
  assign wr_oneshot     = wr_req && (ptr_ff == `TMR_WR_ONESHOT);
  assign wr_fault_queue = wr_req && (ptr_ff == `TMR_RW_FAULTQ);
  assign status_read    = rd_req && (ptr_ff == `TMR_RD_STATUS);

  // Only bits 7, 6, 5, 4 and 2 take writes; 3, 1 and 0 keep their reset pattern.
  assign nxt_config = wr_config ?
                      ((wr_data & `TMR_CFG_WR_MASK) | (`TMR_CFG_RESET & ~`TMR_CFG_WR_MASK)) :
                      config_ff;

  // Upper four rate bits are reserved and never stored.
  assign nxt_rate        = wr_rate ? wr_data[3:0] : rate_code_ff;
  assign nxt_fault_queue = wr_fault_queue ? (wr_data & `TMR_FAULTQ_WR_MASK) : fault_queue_ff;

  assign trip_events = {meas.local_upper_trip_flag,
                        meas.local_lower_trip_flag,
                        meas.remote_upper_trip_flag,
                        meas.remote_lower_trip_flag,
                        meas.diode_open};

  // A trip in the same cycle as the clearing read survives, so no event is lost.
  assign nxt_sticky = (status_read ? 5'h00 : sticky_ff) | trip_events;

  always_comb begin
    status_word                   = 8'h00;
    status_word[`TMR_ST_BUSY_BIT] = meas.busy;
    status_word[`TMR_ST_LHI_BIT]  = sticky_ff[4];
    status_word[`TMR_ST_LLO_BIT]  = sticky_ff[3];
    status_word[`TMR_ST_RHI_BIT]  = sticky_ff[2];
    status_word[`TMR_ST_RLO_BIT]  = sticky_ff[1];
    status_word[`TMR_ST_OPEN_BIT] = sticky_ff[0];
    status_word[`TMR_ST_ROT_BIT]  = meas.remote_overtemp_flag;
    status_word[`TMR_ST_LOT_BIT]  = meas.local_overtemp_flag;
  end

  // Read mux; unknown read addresses, including write-only ones, return zero.
  always_comb begin
    case (ptr_ff)
      `TMR_RD_STATUS: nxt_rd_data = status_word;
      `TMR_RD_CONFIG: nxt_rd_data = config_ff;
      `TMR_RD_RATE:   nxt_rd_data = {4'h0, rate_code_ff};
      `TMR_RW_FAULTQ: nxt_rd_data = fault_queue_ff;
      `TMR_RD_PARTID: nxt_rd_data = PART_CODE;
      `TMR_RD_MAKER:  nxt_rd_data = MAKER_CODE;
      `TMR_RD_REV:    nxt_rd_data = REV_CODE;
      default:        nxt_rd_data = 8'h00;
    endcase
  end

  assign mask_on     = config_ff[`TMR_CFG_MASK_BIT];
  assign role_second = config_ff[`TMR_CFG_ROLE_BIT];

  // Busy and the two overtemperature levels are kept out of the limit interrupt.
  assign limit_pending = |sticky_ff;

  // In the second role the pin follows its comparator and the mask is ignored.
  assign nxt_shared_active = role_second ?
                             (meas.remote_second_over || meas.local_second_over) :
                             (limit_pending && !mask_on);

  // Comparator levels pass on regardless of standby, so limit rewrites show at once.
  assign nxt_overtemp_active = meas.remote_overtemp_flag || meas.local_overtemp_flag;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ptr_ff <= 8'h00;
    end else if (ptr_load) begin
      ptr_ff <= wr_data;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      config_ff      <= `TMR_CFG_RESET;
      rate_code_ff   <= `TMR_RATE_RESET;
      fault_queue_ff <= `TMR_FAULTQ_RESET;
    end else begin
      config_ff      <= nxt_config;
      rate_code_ff   <= nxt_rate;
      fault_queue_ff <= nxt_fault_queue;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sticky_ff <= 5'h00;
    end else begin
      sticky_ff <= nxt_sticky;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rd_data_ff  <= 8'h00;
      rd_valid_ff <= 1'b0;
    end else begin
      rd_data_ff  <= rd_req ? nxt_rd_data : rd_data_ff;
      rd_valid_ff <= rd_req;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cfg_ff <= '0;
    end else begin
      cfg_ff.standby         <= nxt_config[`TMR_CFG_STANDBY_BIT];
      cfg_ff.beta_cancel_off <= nxt_config[`TMR_CFG_BETA_OFF_BIT];
      cfg_ff.ext_range       <= nxt_config[`TMR_CFG_RANGE_BIT];
    end
  end

  // Open-drain pins: the data flop holds low and the enable goes low to pull.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      shared_pin_out_ff      <= 1'b0;
      shared_pin_oe_n_ff     <= 1'b1;
      overtemp_out_n_ff      <= 1'b0;
      overtemp_out_n_oe_n_ff <= 1'b1;
    end else begin
      shared_pin_out_ff      <= 1'b0;
      shared_pin_oe_n_ff     <= !nxt_shared_active;
      overtemp_out_n_ff      <= 1'b0;
      overtemp_out_n_oe_n_ff <= !nxt_overtemp_active;
    end
  end

  tmr_rate_timer #(
    .MS_CYCLES (MS_CYCLES)
  ) u_rate_timer (
    .sys_clk       (sys_clk),
    .rst           (rst),
    .rate_code     (rate_code_ff),
    .standby       (config_ff[`TMR_CFG_STANDBY_BIT]),
    .one_shot      (wr_oneshot),
    .conv_start_ff (conv_start_ff)
  );
endmodule // tmr_regs

`default_nettype wire

/* testbench/tmr_regs_sva.sv */
// Purpose: Port-level checks for the monitor register bank.
// Assumes: The pointer is mirrored from ptr_load; no load and access share a cycle.
// Notes: Sticky flags and the shared pin role are judged by the bench.
`timescale 1ns/1ps
`default_nettype none
module tmr_regs_sva (
  input wire logic                  sys_clk,
  input wire logic                  rst,
  input wire logic                  ptr_load,
  input wire logic                  wr_req,
  input wire logic                  rd_req,
  input wire logic [7:0]            wr_data,
  input wire tmr_pkg::tmr_meas_type meas,
  input wire logic [7:0]            rd_data_ff,
  input wire logic                  rd_valid_ff,
  input wire tmr_pkg::tmr_cfg_type  cfg_ff,
  input wire logic [3:0]            rate_code_ff,
  input wire logic                  conv_start_ff,
  input wire logic                  overtemp_out_n_oe_n_ff
);
  import tmr_pkg::*;
  logic [7:0] ptr_ff;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) ptr_ff <= 8'h00;
    else if (ptr_load) ptr_ff <= wr_data;
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence s_wr(logic [7:0] a); wr_req && !ptr_load && ptr_ff == a; endsequence
  sequence s_rd(logic [7:0] a); rd_req && !ptr_load && ptr_ff == a; endsequence
  read_answer_a: assert property (1'b1 |-> rd_valid_ff == $past(rd_req))
    else $error("read answer not one cycle after request");
  cfg_write_a: assert property (s_wr(8'h09) |=> cfg_ff ==
    {$past(wr_data[6]), $past(wr_data[4]), $past(wr_data[2])}) else $error("config write lost");
  rate_write_a: assert property (s_wr(8'h0a) |=> rate_code_ff == $past(wr_data[3:0]))
    else $error("rate write lost");
  one_shot_a: assert property (s_wr(8'h0f) |=> conv_start_ff)
    else $error("single conversion not started");
  standby_quiet_a: assert property (cfg_ff.standby && !(wr_req && ptr_ff == 8'h0f)
    |=> !conv_start_ff) else $error("conversion started in standby");
  ot_active_a: assert property (meas.remote_overtemp_flag || meas.local_overtemp_flag
    |=> !overtemp_out_n_oe_n_ff) else $error("overtemp pin not pulled low");
  ot_idle_a: assert property (!meas.remote_overtemp_flag && !meas.local_overtemp_flag
    |=> overtemp_out_n_oe_n_ff) else $error("overtemp pin pulled low without cause");
  status_live_a: assert property (s_rd(8'h02) |=> rd_data_ff[7] == $past(meas.busy)
    && rd_data_ff[1:0] == {$past(meas.remote_overtemp_flag), $past(meas.local_overtemp_flag)})
    else $error("live status bits wrong");
  unmapped_read_a: assert property (s_rd(8'h0f) |=> rd_data_ff == 8'h00)
    else $error("write-only address read nonzero");
endmodule // tmr_regs_sva
bind tmr_regs tmr_regs_sva i_sva (.sys_clk(sys_clk), .rst(rst), .ptr_load(ptr_load),
  .wr_req(wr_req), .rd_req(rd_req), .wr_data(wr_data), .meas(meas), .rd_data_ff(rd_data_ff),
  .rd_valid_ff(rd_valid_ff), .cfg_ff(cfg_ff), .rate_code_ff(rate_code_ff),
  .conv_start_ff(conv_start_ff), .overtemp_out_n_oe_n_ff(overtemp_out_n_oe_n_ff));
`default_nettype wire

/* testbench/tmr_host_model.sv */
// Purpose: Bus host stand-in that loads the pointer, then writes or reads.
// Assumes: Each request is a one-cycle pulse taken at a rising edge.
// Notes: Released data lines show the inverse of the last byte, never a stale copy.
`timescale 1ns/1ps
`default_nettype none
module tmr_host_model (
  input  wire logic       sys_clk,
  output var  logic       ptr_load,
  output var  logic       wr_req,
  output var  logic       rd_req,
  output var  logic [7:0] wr_data
);
  initial {ptr_load, wr_req, rd_req, wr_data} = 11'h000;
  task automatic op(input logic [2:0] k, input logic [7:0] d);
    @(posedge sys_clk);
    #1 {ptr_load, wr_req, rd_req} = k;
    wr_data = d;
    @(posedge sys_clk);
    #1 {ptr_load, wr_req, rd_req} = 3'h0;
    wr_data = ~d;
  endtask
  // Select by pointer first, then access through it.
  task automatic put(input logic [7:0] a, input logic [7:0] d);
    op(3'h4, a);
    op(3'h2, d);
  endtask
  task automatic get(input logic [7:0] a);
    op(3'h4, a);
    op(3'h1, 8'h00);
  endtask
endmodule // tmr_host_model
`default_nettype wire

/* testbench/tb.sv */
// Purpose: Self-checking bench for the monitor register bank.
// Assumes: MS_CYCLES of 4 shortens every conversion period.
// Notes: Reads queue their expected byte; a monitor compares on each answer.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import tmr_pkg::*;
  localparam int unsigned MS    = 4;
  localparam logic [7:0]  PART  = 8'h5a; // Arbitrary value.
  localparam logic [7:0]  MAKER = 8'h3c; // Arbitrary value.
  localparam logic [7:0]  REV   = 8'h01; // Arbitrary value.
  logic         sys_clk = 1'b0;
  logic         rst = 1'b1;
  logic         ptr_load, wr_req, rd_req, rd_valid_ff, conv_start_ff, sp_oe_n, ot_oe_n;
  logic         sp_out, ot_out;
  logic [7:0]   wr_data, rd_data_ff, fq;
  logic [3:0]   rate_code_ff;
  tmr_meas_type meas = '0;
  tmr_cfg_type  cfg_ff;
  int           error_cnt = 0, comparisons = 0, starts = 0, s0;
  logic [7:0]   exp_q[$];
  always #5 sys_clk = ~sys_clk;
  tmr_host_model i_host (.sys_clk(sys_clk), .ptr_load(ptr_load), .wr_req(wr_req),
    .rd_req(rd_req), .wr_data(wr_data));
  tmr_regs #(.MS_CYCLES(MS), .PART_CODE(PART), .MAKER_CODE(MAKER), .REV_CODE(REV)) i_dut (
    .sys_clk(sys_clk), .rst(rst), .ptr_load(ptr_load), .wr_req(wr_req), .rd_req(rd_req),
    .wr_data(wr_data), .meas(meas), .rd_data_ff(rd_data_ff), .rd_valid_ff(rd_valid_ff),
    .cfg_ff(cfg_ff), .rate_code_ff(rate_code_ff), .fault_queue_ff(fq), .conv_start_ff(conv_start_ff),
    .shared_pin_out_ff(sp_out), .shared_pin_oe_n_ff(sp_oe_n), .overtemp_out_n_ff(ot_out),
    .overtemp_out_n_oe_n_ff(ot_oe_n));
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    i_host.get(a);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic wrap_up;
    if (exp_q.size() != 0) chk("pending_reads", 8'h00, 8'(exp_q.size()));
    $display("comparisons %0d errors %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Counted mid-cycle so the pulse is never read in the step of the edge that launches it.
  always @(negedge sys_clk) if (conv_start_ff === 1'b1) starts++;
  always @(negedge sys_clk) if (rd_valid_ff === 1'b1) begin
    if (exp_q.size() == 0) chk("unrequested_read", 8'h00, 8'hff);
    else chk("rd_data", exp_q.pop_front(), rd_data_ff);
  end
  initial begin
    static logic [7:0] ra[8] = '{8'h03, 8'h04, 8'h22, 8'h3d, 8'hfe, 8'hff, 8'h0f, 8'h0a};
    static logic [7:0] re[8] = '{8'h08, 8'h06, 8'h01, PART, MAKER, REV, 8'h00, 8'h00};
    logic [7:0] r;
    int t, n;
    void'($urandom(46));
    tick(6);
    rst = 1'b0;
    foreach (ra[i]) rd(ra[i], re[i]);
    i_host.put(8'h09, 8'hff);
    chk("cfg_ff", 8'h07, {5'h00, cfg_ff});
    i_host.put(8'h03, 8'h00); // Read address takes no write.
    rd(8'h03, 8'hfc);
    r = 8'($urandom);
    i_host.put(8'h09, r);
    chk("cfg_ff", {5'h00, r[6], r[4], r[2]}, {5'h00, cfg_ff});
    rd(8'h03, (r & 8'hf4) | 8'h08);
    i_host.put(8'h09, 8'h10);
    chk("cfg_ff", 8'h02, {5'h00, cfg_ff});
    i_host.put(8'h22, 8'hff);
    chk("fault_queue_ff", 8'hcf, fq);
    rd(8'h22, 8'hcf);
    i_host.put(8'h09, 8'h00);
    for (int c = 0; c <= 10; c++) begin
      i_host.put(8'h0a, {4'($urandom), 4'(c)});
      chk("rate_code_ff", 8'(c), {4'h0, rate_code_ff});
      rd(8'h04, 8'(c));
    end
    i_host.put(8'h04, 8'h03);
    rd(8'h04, 8'h0a);
    for (int c = 10; c >= 9; c--) begin
      i_host.put(8'h0a, 8'(c));
      t = 0;
      n = 0;
      for (int k = 0; k < 4000 && t < 2; k++) begin
        tick(1);
        if (conv_start_ff === 1'b1) begin
          t++;
          n = k - n;
        end
      end
      chk("conv_gap", (c == 10) ? 8'(27 * MS) : 8'(50 * MS), (t < 2) ? 8'h00 : 8'(n));
    end
    i_host.put(8'h09, 8'h40);
    meas.local_overtemp_flag = 1'b1;
    tick(2);
    s0 = starts;
    i_host.put(8'h0f, 8'h5a);
    tick(300);
    chk("standby_starts", 8'(s0 + 1), 8'(starts));
    chk("ot_oe_n", 8'h00, {7'h00, ot_oe_n});
    rd(8'h03, 8'h48);
    meas.local_overtemp_flag = 1'b0;
    i_host.put(8'h09, 8'h00);
    for (int b = 2; b <= 6; b++) begin
      meas[b + 2] = 1'b1;
      tick(1);
      meas[b + 2] = 1'b0;
      tick(1);
      chk("alert_oe_n", 8'h00, {7'h00, sp_oe_n});
      rd(8'h02, 8'(1 << b));
      rd(8'h02, 8'h00);
      chk("alert_oe_n", 8'h01, {7'h00, sp_oe_n});
    end
    i_host.put(8'h09, 8'h80);
    meas.diode_open = 1'b1;
    tick(3);
    meas.diode_open = 1'b0;
    chk("masked_oe_n", 8'h01, {7'h00, sp_oe_n});
    rd(8'h02, 8'h04);
    i_host.put(8'h09, 8'ha0);
    meas.remote_second_over = 1'b1;
    tick(2);
    chk("second_oe_n", 8'h00, {7'h00, sp_oe_n});
    meas.remote_second_over = 1'b0;
    tick(2);
    chk("second_oe_n", 8'h01, {7'h00, sp_oe_n});
    i_host.put(8'h09, 8'h00);
    {meas.busy, meas.remote_overtemp_flag, meas.local_overtemp_flag} = 3'h7;
    i_host.put(8'h02, 8'hff); // Status takes no write.
    chk("live_oe_n", 8'h01, {7'h00, sp_oe_n});
    rd(8'h02, 8'h83);
    chk("pin_data", 8'h00, {6'h00, sp_out, ot_out});
    chk("ot_oe_n", 8'h00, {7'h00, ot_oe_n});
    tick(3);
    wrap_up;
  end
endmodule // tb
`default_nettype wire
